// [include/axis_cfg_pkg.sv]
`default_nettype none
package axis_cfg_pkg;
  localparam logic [7:0] NUM_SPEED_THRESH   = 8'h16;
  localparam logic [7:0] NUM_LOAD_MIN_SPEED = 8'h17;
  localparam logic [7:0] NUM_RIGHT_POL      = 8'h18;
  localparam logic [7:0] NUM_LEFT_POL       = 8'h19;
  localparam logic [7:0] NUM_SOFT_STOP      = 8'h1a;
  localparam logic [7:0] NUM_HS_CHOPPER     = 8'h1b;
  localparam logic [7:0] NUM_HS_FULLSTEP    = 8'h1c;
  localparam logic [7:0] NUM_MEAS_SPEED     = 8'h1d;
  localparam logic [7:0] NUM_PD_RAMP        = 8'h1f;
  localparam logic [7:0] NUM_LOAD_PULSE     = 8'h20;
  localparam logic [7:0] NUM_LOAD_STALL     = 8'h21;
  localparam logic [7:0] NUM_REL_BASE       = 8'h7f;
  localparam logic [7:0] NUM_USTEP_RES      = 8'h8c;
  localparam logic [7:0] NUM_BLANK_TIME     = 8'ha2;
  localparam logic [7:0] NUM_CHOP_MODE      = 8'ha3;
  localparam logic [7:0] NUM_FD_CMP_DIS     = 8'ha4;
  localparam logic [7:0] NUM_HYST_END       = 8'ha5;
  localparam logic [7:0] NUM_HYST_START     = 8'ha6;
  localparam logic [7:0] NUM_OFF_TIME       = 8'ha7;

  localparam int          CLK_HZ         = 10000000;
  localparam int          PD_STEP_US     = 163840;
  localparam int          PD_STEP_CYCLES = CLK_HZ / 1000000 * PD_STEP_US;
  localparam int          SETTLE_CYCLES  = 16;
  localparam logic [9:0]  OFF_BASE       = 10'h00c;
  localparam logic [9:0]  OFF_MIN        = 10'h040;
  localparam logic [3:0]  USTEP_MAX      = 4'h8;
  localparam logic [3:0]  HSTART_MAX     = 4'h8;

  localparam logic [22:0] RST_SPEED      = 23'h000000;
  localparam logic [1:0]  RST_BLANK      = 2'h2;
  localparam logic [3:0]  RST_OFF        = 4'h3;
  localparam logic [3:0]  RST_USTEP      = 4'h8;
  localparam logic [3:0]  RST_HEND       = 4'h0;
  localparam logic [3:0]  RST_HSTART     = 4'h4;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  number;
    logic [31:0] value;
  } param_cmd_s;

  typedef struct packed {
    logic        chopper_constant_off;
    logic        fullstep;
    logic        adaptive_current_ok;
    logic        load_commutation;
    logic        fd_cmp_disable;
    logic        freewheel;
    logic [9:0]  off_cycles;
    logic [1:0]  blank_time;
    logic [3:0]  hyst_end_or_fast;
    logic [3:0]  hyst_start_or_sine;
    logic [8:0]  ustep_per_full;
  } chopper_ctl_s;

  typedef enum logic [1:0] {PD_IDLE, PD_SETTLE, PD_RAMP, PD_DONE} pd_state_e;
endpackage : axis_cfg_pkg
`default_nettype wire

// [hdl/axis_cfg.sv]
`default_nettype none
module axis_cfg
  import axis_cfg_pkg::*;
#(
  parameter int PD_STEP = PD_STEP_CYCLES,
  parameter int SETTLE  = SETTLE_CYCLES
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire param_cmd_s   cmd_in,
  output logic              reply_valid_out,
  output logic [31:0]       reply_value_out,
  output logic              reply_error_out,
  input  wire logic [22:0]  speed_in,
  input  wire logic         motion_done_in,
  input  wire logic         right_switch_in,
  input  wire logic         left_switch_in,
  output logic              right_stop_out,
  output logic              left_stop_out,
  output logic              soft_stop_out,
  output logic              relative_from_actual_out,
  output logic [9:0]        load_pulse_width_out,
  output logic [7:0]        stall_sense_out,
  output chopper_ctl_s      chopper_out,
  output logic              power_down_active_out,
  output logic [3:0]        power_down_level_out
);

  default clocking check_clock @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  // -------------------------------------------------------
  // Settings
  // -------------------------------------------------------
  logic [22:0] speed_thresh;
  logic [22:0] load_min_speed;
  logic        right_pol;
  logic        left_pol;
  logic        soft_stop;
  logic        hs_chopper;
  logic        hs_fullstep;
  logic [3:0]  pd_ramp;
  logic [9:0]  load_pulse;
  logic [7:0]  load_stall;
  logic        rel_base;
  logic [3:0]  ustep_res;
  logic [1:0]  blank_time;
  logic        chop_mode;
  logic        fd_cmp_dis;
  logic [3:0]  hyst_end;
  logic [3:0]  hyst_start;
  logic [3:0]  off_time;
  logic [22:0] meas_speed;

  function automatic logic known_number(input logic [7:0] n);
    case (n)
      NUM_SPEED_THRESH, NUM_LOAD_MIN_SPEED, NUM_RIGHT_POL, NUM_LEFT_POL,
      NUM_SOFT_STOP, NUM_HS_CHOPPER, NUM_HS_FULLSTEP, NUM_MEAS_SPEED,
      NUM_PD_RAMP, NUM_LOAD_PULSE, NUM_LOAD_STALL, NUM_REL_BASE,
      NUM_USTEP_RES, NUM_BLANK_TIME, NUM_CHOP_MODE, NUM_FD_CMP_DIS,
      NUM_HYST_END, NUM_HYST_START, NUM_OFF_TIME: known_number = 1'b1;
      default: known_number = 1'b0;
    endcase
  endfunction : known_number

  logic wr;
  assign wr = cmd_in.write;

  // Out-of-range microstep resolution and hysteresis start codes refused so those settings stay meaningful
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      speed_thresh   <= RST_SPEED;
      load_min_speed <= RST_SPEED;
      right_pol      <= 1'b0;
      left_pol       <= 1'b0;
      soft_stop      <= 1'b0;
      hs_chopper     <= 1'b0;
      hs_fullstep    <= 1'b0;
      pd_ramp        <= 4'h0;
      load_pulse     <= 10'h000;
      load_stall     <= 8'h00;
      rel_base       <= 1'b0;
      ustep_res      <= RST_USTEP;
      blank_time     <= RST_BLANK;
      chop_mode      <= 1'b0;
      fd_cmp_dis     <= 1'b0;
      hyst_end       <= RST_HEND;
      hyst_start     <= RST_HSTART;
      off_time       <= RST_OFF;
    end else if (wr) begin
      case (cmd_in.number)
        NUM_SPEED_THRESH:   speed_thresh   <= cmd_in.value[22:0];
        NUM_LOAD_MIN_SPEED: load_min_speed <= cmd_in.value[22:0];
        NUM_RIGHT_POL:      right_pol      <= cmd_in.value[0];
        NUM_LEFT_POL:       left_pol       <= cmd_in.value[0];
        NUM_SOFT_STOP:      soft_stop      <= cmd_in.value[0];
        NUM_HS_CHOPPER:     hs_chopper     <= cmd_in.value[0];
        NUM_HS_FULLSTEP:    hs_fullstep    <= cmd_in.value[0];
        NUM_PD_RAMP:        pd_ramp        <= cmd_in.value[3:0];
        NUM_LOAD_PULSE:     load_pulse     <= cmd_in.value[9:0];
        NUM_LOAD_STALL:     load_stall     <= cmd_in.value[7:0];
        NUM_REL_BASE:       rel_base       <= cmd_in.value[0];
        NUM_USTEP_RES: begin
          if (cmd_in.value[31:4] == 28'h0
              && cmd_in.value[3:0] <= USTEP_MAX) begin
            ustep_res <= cmd_in.value[3:0];
          end
        end
        NUM_BLANK_TIME:     blank_time     <= cmd_in.value[1:0];
        NUM_CHOP_MODE:      chop_mode      <= cmd_in.value[0];
        NUM_FD_CMP_DIS:     fd_cmp_dis     <= cmd_in.value[0];
        NUM_HYST_END:       hyst_end       <= cmd_in.value[3:0];
        NUM_HYST_START: begin
          if (cmd_in.value[31:4] == 28'h0
              && cmd_in.value[3:0] <= HSTART_MAX) begin
            hyst_start <= cmd_in.value[3:0];
          end
        end
        NUM_OFF_TIME:       off_time       <= cmd_in.value[3:0];
        default: ; // Status numbers ignore writes
      endcase
    end
  end

  // Sampled speed, read-only status that also feeds chopper control and power-down ramp
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meas_speed <= RST_SPEED;
    end else begin
      meas_speed <= speed_in;
    end
  end

  // -------------------------------------------------------
  // Read-back reply
  // -------------------------------------------------------
  logic [31:0] next_reply;
  always_comb begin
    next_reply = 32'h0;
    case (cmd_in.number)
      NUM_SPEED_THRESH:   next_reply = {9'h0, speed_thresh};
      NUM_LOAD_MIN_SPEED: next_reply = {9'h0, load_min_speed};
      NUM_RIGHT_POL:      next_reply = {31'h0, right_pol};
      NUM_LEFT_POL:       next_reply = {31'h0, left_pol};
      NUM_SOFT_STOP:      next_reply = {31'h0, soft_stop};
      NUM_HS_CHOPPER:     next_reply = {31'h0, hs_chopper};
      NUM_HS_FULLSTEP:    next_reply = {31'h0, hs_fullstep};
      NUM_MEAS_SPEED:     next_reply = {9'h0, meas_speed};
      NUM_PD_RAMP:        next_reply = {28'h0, pd_ramp};
      NUM_LOAD_PULSE:     next_reply = {22'h0, load_pulse};
      NUM_LOAD_STALL:     next_reply = {24'h0, load_stall};
      NUM_REL_BASE:       next_reply = {31'h0, rel_base};
      NUM_USTEP_RES:      next_reply = {28'h0, ustep_res};
      NUM_BLANK_TIME:     next_reply = {30'h0, blank_time};
      NUM_CHOP_MODE:      next_reply = {31'h0, chop_mode};
      NUM_FD_CMP_DIS:     next_reply = {31'h0, fd_cmp_dis};
      NUM_HYST_END:       next_reply = {28'h0, hyst_end};
      NUM_HYST_START:     next_reply = {28'h0, hyst_start};
      NUM_OFF_TIME:       next_reply = {28'h0, off_time};
      default:            next_reply = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reply_valid_out <= 1'b0;
      reply_value_out <= 32'h0;
      reply_error_out <= 1'b0;
    end else begin
      reply_valid_out <= cmd_in.read | cmd_in.write;
      reply_error_out <= (cmd_in.read | cmd_in.write)
                         & ~known_number(cmd_in.number);
      if (cmd_in.read) begin
        reply_value_out <= next_reply;
      end
    end
  end

  // -------------------------------------------------------
  // End switches, three-stage sampling
  // -------------------------------------------------------
  logic [2:0] right_sync;
  logic [2:0] left_sync;
  logic       right_level;
  logic       left_level;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      right_sync  <= 3'h0;
      left_sync   <= 3'h0;
      right_level <= 1'b0;
      left_level  <= 1'b0;
    end else begin
      right_sync <= {right_sync[1:0], right_switch_in};
      left_sync  <= {left_sync[1:0], left_switch_in};
      if (right_sync[1] == right_sync[2]) begin
        right_level <= right_sync[2];
      end
      if (left_sync[1] == left_sync[2]) begin
        left_level <= left_sync[2];
      end
    end
  end

  assign right_stop_out = right_level ^ right_pol;
  assign left_stop_out  = left_level ^ left_pol;
  // Ramp logic outside honours this flag on a switch stop
  assign soft_stop_out  = soft_stop;
  assign relative_from_actual_out = rel_base;
  assign load_pulse_width_out     = load_pulse;
  assign stall_sense_out          = load_stall;

  // -------------------------------------------------------
  // Chopper control
  // -------------------------------------------------------
  logic        above_thresh;
  logic [9:0]  off_raw;
  chopper_ctl_s next_chop;

  always_comb begin
    above_thresh = meas_speed > speed_thresh;
    off_raw      = OFF_BASE + {off_time, 5'h00};
    next_chop.chopper_constant_off =
      chop_mode ^ (hs_chopper & above_thresh);
    next_chop.fullstep = hs_fullstep & above_thresh;
    next_chop.adaptive_current_ok = ~above_thresh;
    next_chop.load_commutation = meas_speed >= load_min_speed;
    next_chop.fd_cmp_disable =
      next_chop.chopper_constant_off & fd_cmp_dis;
    next_chop.freewheel = off_time == 4'h0;
    next_chop.off_cycles = (off_raw < OFF_MIN) ? OFF_MIN : off_raw;
    next_chop.blank_time = blank_time;
    next_chop.hyst_end_or_fast = hyst_end;
    next_chop.hyst_start_or_sine = hyst_start;
    next_chop.ustep_per_full = 9'h001 << ustep_res;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      chopper_out <= '0;
    end else begin
      chopper_out <= next_chop;
    end
  end

  // -------------------------------------------------------
  // Power-down ramp
  // -------------------------------------------------------
  pd_state_e   pd_state;
  logic [31:0] pd_count;
  logic [3:0]  pd_steps;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pd_state <= PD_IDLE;
      pd_count <= 32'h0;
      pd_steps <= 4'h0;
    end else if (!motion_done_in || meas_speed != 23'h0) begin
      pd_state <= PD_IDLE;
      pd_count <= 32'h0;
      pd_steps <= 4'h0;
    end else begin
      case (pd_state)
        PD_IDLE: begin
          pd_state <= PD_SETTLE;
          pd_count <= 32'h0;
        end
        PD_SETTLE: begin
          if (pd_count >= 32'(SETTLE - 1)) begin
            pd_count <= 32'h0;
            pd_steps <= pd_ramp;
            pd_state <= (pd_ramp == 4'h0) ? PD_DONE : PD_RAMP;
          end else begin
            pd_count <= pd_count + 32'h1;
          end
        end
        PD_RAMP: begin
          if (pd_count >= 32'(PD_STEP - 1)) begin
            pd_count <= 32'h0;
            pd_steps <= pd_steps - 4'h1;
            if (pd_steps == 4'h1) begin
              pd_state <= PD_DONE;
            end
          end else begin
            pd_count <= pd_count + 32'h1;
          end
        end
        PD_DONE: pd_state <= PD_DONE;
        default: pd_state <= PD_IDLE;
      endcase
    end
  end

  assign power_down_active_out = pd_state == PD_RAMP || pd_state == PD_DONE;
  assign power_down_level_out  = pd_steps;

  // -------------------------------------------------------
  // Checks
  // -------------------------------------------------------
  // Output register still holds its reset image one cycle after release
  a_off_floor: assert property (
    !$past(reset_in) |-> chopper_out.off_cycles >= OFF_MIN)
    else $error("off time below floor");
  a_off_freewheel: assert property (
    (off_time == 4'h0) |=> chopper_out.freewheel)
    else $error("no freewheel on zero off time");
  a_right_pol: assert property (
    right_stop_out == (right_level ^ right_pol))
    else $error("right polarity wrong");
  a_left_pol: assert property (
    left_stop_out == (left_level ^ left_pol))
    else $error("left polarity wrong");
  a_ro_ignored: assert property (
    (wr && cmd_in.number == NUM_MEAS_SPEED) |=> $stable(speed_thresh))
    else $error("status write changed setting");
  a_reply_pulse: assert property (
    (cmd_in.read || wr) |=> reply_valid_out)
    else $error("command without reply");
  a_read_back: assert property (
    (cmd_in.read && cmd_in.number == NUM_PD_RAMP && !wr) |=>
      reply_value_out == {28'h0, pd_ramp})
    else $error("read back mismatch");
  a_adapt_off: assert property (
    above_thresh |=> !chopper_out.adaptive_current_ok)
    else $error("adaptive current kept above threshold");
  a_load_min: assert property (
    (meas_speed < load_min_speed) |=> !chopper_out.load_commutation)
    else $error("load commutation below minimum speed");
  a_mode_base: assert property (
    !hs_chopper |=> chopper_out.chopper_constant_off == $past(chop_mode))
    else $error("chopper mode not followed");
  a_hs_fullstep: assert property (
    (hs_fullstep && above_thresh && $stable(hs_fullstep)) |=>
      chopper_out.fullstep)
    else $error("full step not taken");
  a_fd_cmp_mode: assert property (
    !chopper_out.chopper_constant_off |-> !chopper_out.fd_cmp_disable)
    else $error("comparator disable outside constant off mode");
  a_blank_pass: assert property (
    !$past(reset_in) |-> chopper_out.blank_time == $past(blank_time))
    else $error("blank time not applied");
  a_hend_pass: assert property (
    !$past(reset_in) |-> chopper_out.hyst_end_or_fast == $past(hyst_end))
    else $error("hysteresis end not applied");
  a_ustep_range: assert property (
    ustep_res <= USTEP_MAX)
    else $error("resolution code out of range");
  a_ustep_decode: assert property (
    (ustep_res == 4'h0) |=> chopper_out.ustep_per_full == 9'h001)
    else $error("full step code not decoded");
  a_hstart_rng: assert property (
    hyst_start <= HSTART_MAX)
    else $error("hysteresis start out of range");
  a_ramp_wait: assert property (
    $rose(pd_state == PD_RAMP) |-> $past(pd_state) == PD_SETTLE)
    else $error("ramp started without settling");
  a_ramp_motion: assert property (
    !motion_done_in |=> !power_down_active_out)
    else $error("power down during motion");
  a_pd_zero: assert property (
    (pd_state == PD_SETTLE && pd_ramp == 4'h0) |=> pd_state != PD_RAMP)
    else $error("ramp entered with zero length");

  // -------------------------------------------------------
  // Coverage
  // -------------------------------------------------------
  c_ramp_done: cover property (@(posedge clk_in) pd_state == PD_DONE);
  c_chop_swap: cover property (@(posedge clk_in)
    chopper_out.chopper_constant_off && !chop_mode);
  c_left_stop: cover property (@(posedge clk_in) left_stop_out);
  c_freewheel: cover property (@(posedge clk_in) chopper_out.freewheel);
  c_ramp_active: cover property (@(posedge clk_in) pd_state == PD_RAMP);
endmodule : axis_cfg
`default_nettype wire

// [test/host_model.sv]
`default_nettype none
module host_model
  import axis_cfg_pkg::*;
(
  input  wire logic        clk_in,
  output param_cmd_s       cmd_out,
  input  wire logic        reply_valid_in,
  input  wire logic [31:0] reply_value_in,
  input  wire logic        reply_error_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cmd_out = '0;

  // ----------------------------------------
  // One command, one-cycle pulse
  // ----------------------------------------
  // Reply is taken in the cycle after the command edge
  task automatic access(input logic wr, input logic [7:0] num,
                        input logic [31:0] val, output logic [31:0] rdata,
                        output logic ok, output logic err);
    @(posedge clk_in);
    #1 cmd_out = '{write: wr, read: !wr, number: num, value: val};
    @(posedge clk_in);
    #1 cmd_out = '0;
    ok = reply_valid_in;
    err = reply_error_in;
    rdata = reply_value_in;
  endtask : access
endmodule : host_model
`default_nettype wire

// [test/stepper_axis_chopper_config_tb.sv]
`default_nettype none
module stepper_axis_chopper_config_tb
  import axis_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clk_in, reset_in, valid, error, motion_done, rsw, lsw;
  logic         right_stop, left_stop, soft_stop, rel_actual, pd_active;
  logic [31:0]  value;
  logic [22:0]  speed;
  logic [9:0]   load_pw;
  logic [7:0]   stall;
  logic [3:0]   pd_level;
  param_cmd_s   cmd;
  chopper_ctl_s chop;
  int           n_fail = 0;
  int           n_checks = 0;

  initial begin
    clk_in = 0;
    forever #50 clk_in = ~clk_in;
  end

  // Short power-down step and settle keep the run brief
  axis_cfg #(.PD_STEP(4), .SETTLE(2)) axis_cfg_i (
    .clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd),
    .reply_valid_out(valid), .reply_value_out(value),
    .reply_error_out(error), .speed_in(speed),
    .motion_done_in(motion_done), .right_switch_in(rsw),
    .left_switch_in(lsw), .right_stop_out(right_stop),
    .left_stop_out(left_stop), .soft_stop_out(soft_stop),
    .relative_from_actual_out(rel_actual), .load_pulse_width_out(load_pw),
    .stall_sense_out(stall), .chopper_out(chop),
    .power_down_active_out(pd_active), .power_down_level_out(pd_level));

  host_model host_model_i (
    .clk_in(clk_in), .cmd_out(cmd), .reply_valid_in(valid),
    .reply_value_in(value), .reply_error_in(error));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic put(input logic [7:0] num, input logic [31:0] val);
    logic [31:0] d;
    logic v, e;
    host_model_i.access(1'b1, num, val, d, v, e);
    check({v, e}, 32'h2, "write reply");
  endtask : put

  task automatic expect_rd(input logic [7:0] num, input logic [31:0] exp);
    logic [31:0] d;
    logic v, e;
    host_model_i.access(1'b0, num, 32'h0, d, v, e);
    check({v, e}, 32'h2, "read reply");
    check(d, exp, "read value");
  endtask : expect_rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults;
    expect_rd(NUM_BLANK_TIME, 32'h2);
    expect_rd(NUM_OFF_TIME, 32'h3);
    expect_rd(NUM_USTEP_RES, 32'h8);
    expect_rd(NUM_HYST_START, 32'h4);
    check(chop.off_cycles, 32'd108, "off");
    check(chop.ustep_per_full, 32'd256, "us");
  endtask : t_defaults

  task automatic t_readback;
    logic [7:0] nums [16] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b,
      8'h1c, 8'h1f, 8'h20, 8'h21, 8'h7f, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha7};
    int wid [16] = '{23, 23, 1, 1, 1, 1, 1, 4, 10, 8, 1, 2, 1, 1, 4, 4};
    for (int i = 0; i < 16; i++) begin
      put(nums[i], 32'hffffffff);
      expect_rd(nums[i], (32'h1 << wid[i]) - 1);
    end
    check(load_pw, 32'h3ff, "pulse width");
    check(stall, 32'hff, "stall sense");
    check(soft_stop, 32'h1, "soft stop");
    check(rel_actual, 32'h1, "rel base");
    put(NUM_SOFT_STOP, 32'h0);
    put(NUM_REL_BASE, 32'h0);
    tick(1);
    check(soft_stop, 32'h0, "soft stop");
    check(rel_actual, 32'h0, "rel base");
  endtask : t_readback

  task automatic t_status;
    logic [31:0] d;
    logic v, e;
    speed = 23'h012345;
    host_model_i.access(1'b1, NUM_MEAS_SPEED, 32'h0, d, v, e);
    tick(2);
    expect_rd(NUM_MEAS_SPEED, 32'h012345);
    host_model_i.access(1'b0, 8'h1e, 32'h0, d, v, e);
    check({v, e}, 32'h3, "unknown number");
  endtask : t_status

  task automatic t_ustep;
    for (int k = 0; k <= 8; k++) begin
      put(NUM_USTEP_RES, k);
      tick(3);
      check(chop.ustep_per_full, 32'h1 << k, "ustep");
    end
    put(NUM_USTEP_RES, 32'h9);
    expect_rd(NUM_USTEP_RES, 32'h8);
    put(NUM_HYST_START, 32'h8);
    put(NUM_HYST_START, 32'h9);
    expect_rd(NUM_HYST_START, 32'h8);
    check(chop.hyst_start_or_sine, 32'h8, "hstart");
  endtask : t_ustep

  task automatic t_fields;
    put(NUM_BLANK_TIME, 32'h1);
    put(NUM_FD_CMP_DIS, 32'h1);
    put(NUM_HYST_END, 32'h9);
    tick(3);
    check(chop.blank_time, 32'h1, "blank");
    check(chop.fd_cmp_disable, 32'h1, "fdcmp");
    check(chop.hyst_end_or_fast, 32'h9, "hend");
    put(NUM_CHOP_MODE, 32'h0);
    tick(3);
    check(chop.fd_cmp_disable, 32'h0, "fdcmp hyst");
  endtask : t_fields

  task automatic t_offtime;
    int exp;
    put(NUM_CHOP_MODE, 32'h1);
    for (int k = 0; k < 16; k++) begin
      put(NUM_OFF_TIME, k);
      tick(3);
      exp = (12 + 32 * k < 64) ? 64 : 12 + 32 * k;
      check(chop.off_cycles, exp, "off cycles");
      check(chop.freewheel, (k == 0), "freewheel");
    end
  endtask : t_offtime

  task automatic t_speed;
    int sp [4] = '{49, 50, 100, 101};
    logic hi;
    put(NUM_SPEED_THRESH, 32'd100);
    put(NUM_LOAD_MIN_SPEED, 32'd50);
    put(NUM_HS_CHOPPER, 32'h1);
    put(NUM_HS_FULLSTEP, 32'h1);
    for (int m = 0; m < 2; m++) begin
      put(NUM_CHOP_MODE, m);
      for (int i = 0; i < 4; i++) begin
        speed = sp[i];
        hi = sp[i] > 100;
        tick(4);
        check(chop.chopper_constant_off, m ^ hi, "mode");
        check(chop.fullstep, (sp[i] > 100), "fullstep");
        check(chop.adaptive_current_ok, (sp[i] <= 100), "adapt");
        check(chop.load_commutation, (sp[i] >= 50), "load comm");
      end
    end
  endtask : t_speed

  task automatic t_switch;
    for (int p = 0; p < 2; p++) begin
      put(NUM_RIGHT_POL, p);
      put(NUM_LEFT_POL, p);
      for (int l = 0; l < 2; l++) begin
        rsw = l;
        lsw = !l;
        tick(5);
        check(right_stop, l ^ p, "right stop");
        check(left_stop, !l ^ p, "left stop");
      end
    end
  endtask : t_switch

  task automatic t_powerdown;
    int n;
    speed = 23'h0;
    motion_done = 1'b0;
    put(NUM_PD_RAMP, 32'h3);
    tick(20);
    check(pd_active, 32'h0, "early ramp");
    motion_done = 1'b1;
    n = 0;
    while (!pd_active && n < 40) begin
      tick(1);
      n++;
    end
    check((n >= 2 && n < 40), 32'h1, "settle wait");
    n = 0;
    while (pd_level !== 4'h0 && n < 100) begin
      tick(1);
      n++;
    end
    // Three steps of four cycles, one cycle slack each side
    check((n >= 11 && n <= 13), 32'h1, "ramp length");
    motion_done = 1'b0;
    put(NUM_PD_RAMP, 32'h0);
    motion_done = 1'b1;
    tick(4);
    check({pd_active, pd_level}, 32'h10, "instant down");
    motion_done = 1'b0;
  endtask : t_powerdown

  task automatic t_reset;
    put(NUM_OFF_TIME, 32'h5);
    reset_in = 1'b1;
    tick(5);
    reset_in = 1'b0;
    expect_rd(NUM_OFF_TIME, 32'h3);
    check(chop.off_cycles, 32'd108, "off rst");
  endtask : t_reset

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset_in = 1'b1;
    speed = 23'h0;
    motion_done = 1'b0;
    rsw = 1'b0;
    lsw = 1'b0;
    repeat (5) @(posedge clk_in);
    #1 reset_in = 1'b0;
    t_defaults();
    t_readback();
    t_status();
    t_ustep();
    t_fields();
    t_offtime();
    t_speed();
    t_switch();
    t_powerdown();
    t_reset();
    tally_and_finish();
  end

  initial begin
    #3000000;
    n_fail++;
    tally_and_finish();
  end
endmodule : stepper_axis_chopper_config_tb
`default_nettype wire
